//--- hdl/dcf_params.svh
// Constants of the deep FIFO: geometry, flag reset levels and pipeline depths.
// Assumes it is included by the package; both FIFO ends use its macros without including it.
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

`define DCF_DW           72
`define DCF_AW           9
`define DCF_DEPTH        11'h200
`define DCF_HF_BASE      11'h101
`define DCF_XF_STAGES    2
`define DCF_OR_STAGES    3
`define DCF_VIS_STAGES   2
`define DCF_POP_GAP      2'h3
`define DCF_RST_EF_N     1'b0
`define DCF_RST_FF_N     1'b1
`define DCF_RST_OR_N     1'b1
`define DCF_RST_IR_N     1'b0
`define DCF_RST_AE_N     1'b0
`define DCF_RST_HF_N     1'b1
`define DCF_RST_AF_N     1'b1

`endif

//--- hdl/dcf_pkg.sv
// Types shared by both ends of the deep FIFO.
// Assumes dcf_params.svh is on the include path.
`include "dcf_params.svh"

package dcf_pkg;
	typedef logic [`DCF_DW-1:0] dcf_word_t;
	typedef logic [`DCF_AW:0]   dcf_ptr_t;
	typedef logic [`DCF_AW+1:0] dcf_cnt_t;
	typedef logic [`DCF_AW-1:0] dcf_off_t;
	typedef enum logic {DCF_CLASSIC, DCF_FALL_THROUGH} dcf_mode_t;
endpackage : dcf_pkg

//--- hdl/dcf_if.sv
// Pins between the FIFO device and its writer/reader.
// Assumes both ends run on the same clock; the bench supplies it to each end.
`timescale 1ns/1ns
`default_nettype none

interface dcf_if;
	import dcf_pkg::*;
	logic      mode_select_serial_in;
	logic      wr_en_n;
	dcf_word_t data_in;
	logic      rd_en_n;
	dcf_word_t data_out_bus;
	logic      empty_flag_n;
	logic      full_flag_n;
	logic      output_ready_flag_n;
	logic      space_avail_flag_n;
	logic      almost_empty_flag_n;
	logic      almost_full_flag_n;
	logic      half_full_flag_n;

	modport dev (
		input  mode_select_serial_in, wr_en_n, data_in, rd_en_n,
		output data_out_bus, empty_flag_n, full_flag_n, output_ready_flag_n,
		output space_avail_flag_n, almost_empty_flag_n, almost_full_flag_n,
		output half_full_flag_n
	);
	modport usr (
		output mode_select_serial_in, wr_en_n, data_in, rd_en_n,
		input  data_out_bus, empty_flag_n, full_flag_n, output_ready_flag_n,
		input  space_avail_flag_n, almost_empty_flag_n, almost_full_flag_n,
		input  half_full_flag_n
	);
endinterface : dcf_if

`default_nettype wire

//--- hdl/dcf_usr.sv
// Writer and reader end of the deep FIFO, fed by a plain push/pop user port.
// Assumes the device runs on the same clock and that the mode is fixed per build.
`timescale 1ns/1ns
`default_nettype none

module dcf_usr
	import dcf_pkg::*;
#(
	parameter dcf_mode_t FALL_THROUGH = DCF_CLASSIC
) (
	// Clock, reset, enable
	input  wire logic clock_i,
	input  wire logic resetn_i,
	input  wire logic ce_i,
	// FIFO pins
	dcf_if.usr        bus,
	// User push side
	input  wire logic push_i,
	input  wire dcf_word_t push_data_i,
	output logic      push_ready_o,
	// User pop side
	input  wire logic pop_i,
	output dcf_word_t pop_data_o,
	output logic      pop_valid_o
);
	logic      wen_n_r, wen_n_nxt, ren_n_r, ren_n_nxt;
	logic      push_ready_r, push_ready_nxt, pop_valid_r, pop_valid_nxt;
	dcf_word_t din_r, din_nxt, pop_data_r, pop_data_nxt;
	logic [1:0] gap_r, gap_nxt, pend_r, pend_nxt;
	logic      room, ready;

	// Mode is a constant level held through reset so the device can latch it.
	assign bus.mode_select_serial_in = (FALL_THROUGH == DCF_FALL_THROUGH);
	assign bus.wr_en_n = wen_n_r;
	assign bus.data_in = din_r;
	assign bus.rd_en_n = ren_n_r;
	assign push_ready_o = push_ready_r;
	assign pop_data_o = pop_data_r;
	assign pop_valid_o = pop_valid_r;

	always_comb begin
		room = (FALL_THROUGH == DCF_FALL_THROUGH) ? !bus.space_avail_flag_n : bus.full_flag_n;
		ready = (FALL_THROUGH == DCF_FALL_THROUGH) ? !bus.output_ready_flag_n
			: bus.empty_flag_n;
		push_ready_nxt = room;
		wen_n_nxt = !(push_i && push_ready_r);
		din_nxt = push_i ? push_data_i : din_r;
		ren_n_nxt = 1'b1;
		gap_nxt = (gap_r != 2'h0) ? gap_r - 2'h1 : gap_r;
		pend_nxt = {pend_r[0], 1'b0};
		pop_valid_nxt = 1'b0;
		pop_data_nxt = pop_data_r;
		// The gap covers the flag pipeline so a stale flag never starts a read.
		if (pop_i && ready && gap_r == 2'h0) begin
			ren_n_nxt = 1'b0;
			gap_nxt = `DCF_POP_GAP;
			if (FALL_THROUGH == DCF_FALL_THROUGH) begin
				pop_data_nxt = bus.data_out_bus;
				pop_valid_nxt = 1'b1;
			end else begin
				pend_nxt[0] = 1'b1;
			end
		end
		if (FALL_THROUGH == DCF_CLASSIC && pend_r[1]) begin
			pop_data_nxt = bus.data_out_bus;
			pop_valid_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wen_n_r <= 1'b1;
			ren_n_r <= 1'b1;
			din_r <= '0;
			push_ready_r <= 1'b0;
			pop_data_r <= '0;
			pop_valid_r <= 1'b0;
			gap_r <= 2'h0;
			pend_r <= 2'h0;
		end else if (ce_i) begin
			wen_n_r <= wen_n_nxt;
			ren_n_r <= ren_n_nxt;
			din_r <= din_nxt;
			push_ready_r <= push_ready_nxt;
			pop_data_r <= pop_data_nxt;
			pop_valid_r <= pop_valid_nxt;
			gap_r <= gap_nxt;
			pend_r <= pend_nxt;
		end
	end
endmodule : dcf_usr

`default_nettype wire

//--- hdl/dcf_dev.sv
// Deep FIFO device: storage, read timing in classic or fall-through mode,
// and the empty/full, half-full and programmable almost flags.
// Assumes writer and reader share clock_i and obey the read rules below.
//
// What this block does
// - Mode level latched on the first enabled edge after reset release picks timing.
// - Classic reader requests every word with enable.
// - Fall-through first word shows after three edges.
// - Fall-through later words need read enable.
// - Write enable low stores input each edge.
// - Classic empty flag rises after first write.
// - Classic almost-empty rises at n+1 words.
// - Classic almost-empty falls back at n words.
// - Classic half-full falls at half depth plus one.
// - Classic almost-full falls at depth minus m.
// - Classic full flag falls at depth, blocks writes.
// - Classic reads from full release flags upward.
// - Classic last read empties; reads then ignored.
// - Classic empty and full flags two stages.
// - Fall-through output-ready falls after first write.
// - Fall-through almost-empty at n+2, n+1 thresholds.
// - Fall-through half-full at half depth plus two.
// - Fall-through almost-full at depth plus one minus m.
// - Fall-through capacity depth plus one, blocks writes.
// - Fall-through first read from full lowers input-ready.
// - Fall-through last read raises output-ready; reads ignored.
// - Output-ready three stages, input-ready two stages.
//
// The implementer's own choices: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module dcf_dev
	import dcf_pkg::*;
(
	// Clock, reset, enable
	input  wire logic clock_i,
	input  wire logic resetn_i,
	input  wire logic ce_i,
	// FIFO pins
	dcf_if.dev        bus,
	// Flag offsets n and m
	input  wire dcf_off_t empty_offset_i,
	input  wire dcf_off_t full_offset_i
);
	dcf_word_t mem [0:`DCF_DEPTH-1];

	// Control state.
	dcf_mode_t mode_r, mode_nxt;
	logic      armed_r, armed_nxt;
	dcf_ptr_t  wptr_r, wptr_nxt;
	dcf_ptr_t  rptr_r, rptr_nxt;
	dcf_ptr_t  wvis_r [`DCF_VIS_STAGES];
	dcf_ptr_t  wvis_nxt [`DCF_VIS_STAGES];
	logic      ov_r, ov_nxt;
	dcf_word_t dout_r, dout_nxt;

	// Flag pipelines; index 0 is the first stage.
	logic [`DCF_XF_STAGES-1:0] ef_r, ef_nxt, ff_r, ff_nxt, ir_r, ir_nxt;
	logic [`DCF_OR_STAGES-1:0] or_r, or_nxt;
	logic                      ae_r, ae_nxt, hf_r, hf_nxt, af_r, af_nxt;

	// Decoded terms.
	logic      ft, wr_ok, rd_ok, consume, avail, fetch;
	dcf_cnt_t  extra, cap, held, held_nxt;

	function automatic dcf_cnt_t held_of(dcf_ptr_t w, dcf_ptr_t r, logic v);
		held_of = dcf_cnt_t'(dcf_ptr_t'(w - r)) + dcf_cnt_t'(v);
	endfunction : held_of

	assign bus.data_out_bus = dout_r;
	assign bus.empty_flag_n = ef_r[`DCF_XF_STAGES-1];
	assign bus.full_flag_n = ff_r[`DCF_XF_STAGES-1];
	assign bus.space_avail_flag_n = ir_r[`DCF_XF_STAGES-1];
	assign bus.output_ready_flag_n = or_r[`DCF_OR_STAGES-1];
	assign bus.almost_empty_flag_n = ae_r;
	assign bus.half_full_flag_n = hf_r;
	assign bus.almost_full_flag_n = af_r;

	always_comb begin
		// The mode level is caught on the first enabled edge after reset release,
		// since an asynchronous reset may only load constants.
		armed_nxt = 1'b1;
		mode_nxt = armed_r ? mode_r
			: (bus.mode_select_serial_in ? DCF_FALL_THROUGH : DCF_CLASSIC);
		ft = (mode_r == DCF_FALL_THROUGH);

		// The output register adds one word of capacity in fall-through mode.
		extra = dcf_cnt_t'(ft);
		cap = `DCF_DEPTH + extra;
		held = held_of(wptr_r, rptr_r, ov_r);

		// Writes are refused at capacity and dropped silently.
		wr_ok = armed_r && !bus.wr_en_n && (held < cap);
		wptr_nxt = wr_ok ? wptr_r + dcf_ptr_t'(1) : wptr_r;

		// Classic: each read needs enable; an empty FIFO ignores it.
		rd_ok = !ft && !bus.rd_en_n && (wptr_r != rptr_r);

		// Fall-through: the read side sees the write pointer two edges late, so
		// a word written at edge 0 is fetched onto the outputs at edge 3.
		avail = (rptr_r != wvis_r[`DCF_VIS_STAGES-1]);
		consume = ft && !bus.rd_en_n && ov_r;
		fetch = ft && avail && (!ov_r || consume);
		wvis_nxt[0] = wptr_r;
		for (int i = 1; i < `DCF_VIS_STAGES; i++) begin
			wvis_nxt[i] = wvis_r[i-1];
		end

		rptr_nxt = (rd_ok || fetch) ? rptr_r + dcf_ptr_t'(1) : rptr_r;
		dout_nxt = (rd_ok || fetch) ? mem[rptr_r[`DCF_AW-1:0]] : dout_r;
		if (fetch) begin
			ov_nxt = 1'b1;
		end else if (consume) begin
			ov_nxt = 1'b0;
		end else begin
			ov_nxt = ov_r;
		end

		held_nxt = held_of(wptr_nxt, rptr_nxt, ov_nxt);

		// Empty and full levels travel through short pipelines; the reader and
		// writer therefore see them a few edges after the event.
		ef_nxt = {ef_r[`DCF_XF_STAGES-2:0], ft || (held_nxt != '0)};
		ff_nxt = {ff_r[`DCF_XF_STAGES-2:0], ft || (held_nxt < cap)};
		ir_nxt = {ir_r[`DCF_XF_STAGES-2:0], ft && (held_nxt >= cap)};
		or_nxt = {or_r[`DCF_OR_STAGES-2:0], !(ft && ov_nxt)};

		// Threshold flags; each fall-through threshold sits one word higher.
		ae_nxt = held_nxt > dcf_cnt_t'(empty_offset_i) + extra;
		hf_nxt = held_nxt < `DCF_HF_BASE + extra;
		af_nxt = held_nxt < `DCF_DEPTH - dcf_cnt_t'(full_offset_i) + extra;
	end

	// Storage has no reset; only pointers say what it holds.
	always_ff @(posedge clock_i) begin
		if (ce_i && wr_ok) begin
			mem[wptr_r[`DCF_AW-1:0]] <= bus.data_in;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_r <= DCF_CLASSIC;
			armed_r <= 1'b0;
			wptr_r <= '0;
			rptr_r <= '0;
			for (int i = 0; i < `DCF_VIS_STAGES; i++) begin
				wvis_r[i] <= '0;
			end
			ov_r <= 1'b0;
			dout_r <= '0;
			ef_r <= {`DCF_XF_STAGES{`DCF_RST_EF_N}};
			ff_r <= {`DCF_XF_STAGES{`DCF_RST_FF_N}};
			ir_r <= {`DCF_XF_STAGES{`DCF_RST_IR_N}};
			or_r <= {`DCF_OR_STAGES{`DCF_RST_OR_N}};
			ae_r <= `DCF_RST_AE_N;
			hf_r <= `DCF_RST_HF_N;
			af_r <= `DCF_RST_AF_N;
		end else if (ce_i) begin
			mode_r <= mode_nxt;
			armed_r <= armed_nxt;
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			for (int i = 0; i < `DCF_VIS_STAGES; i++) begin
				wvis_r[i] <= wvis_nxt[i];
			end
			ov_r <= ov_nxt;
			dout_r <= dout_nxt;
			ef_r <= ef_nxt;
			ff_r <= ff_nxt;
			ir_r <= ir_nxt;
			or_r <= or_nxt;
			ae_r <= ae_nxt;
			hf_r <= hf_nxt;
			af_r <= af_nxt;
		end
	end
endmodule : dcf_dev

`default_nettype wire

//--- tb/dcf_monitor.sv
// Assertion checker on the classic FIFO pins; it counts held words from the strobes.
// Assumes one clock, steady offsets and a 512-word store.
`timescale 1ns/1ns
`default_nettype none
module dcf_monitor
	import dcf_pkg::*;
(
	// Clock and reset
	input wire logic     clock_i,
	input wire logic     resetn_i,
	// FIFO pins and offsets
	input wire logic     wr_en_n,
	input wire logic     rd_en_n,
	input wire logic     empty_flag_n,
	input wire logic     full_flag_n,
	input wire logic     output_ready_flag_n,
	input wire logic     space_avail_flag_n,
	input wire logic     almost_empty_flag_n,
	input wire logic     almost_full_flag_n,
	input wire logic     half_full_flag_n,
	input wire dcf_off_t empty_offset_i,
	input wire dcf_off_t full_offset_i
);
	logic [9:0] held_r;
	logic [9:0] held_nxt;
	logic [1:0] quiet_r;
	logic [1:0] quiet_nxt;
	// Flags lag the count by up to one edge, so levels are judged once it sat still.
	always_comb begin
		held_nxt = held_r + 10'(!wr_en_n && held_r < 10'h200) - 10'(!rd_en_n && held_r != 10'h0);
		quiet_nxt = (held_nxt != held_r) ? 2'h0 : quiet_r + 2'(quiet_r != 2'h3);
	end
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			held_r <= 10'h0;
			quiet_r <= 2'h3;
		end else begin
			held_r <= held_nxt;
			quiet_r <= quiet_nxt;
		end
	end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);
	empty_level_a: assert property (quiet_r == 2'h3 |-> empty_flag_n == (held_r != 10'h0))
		else $error("empty flag disagrees with count");
	full_level_a: assert property (quiet_r == 2'h3 |-> full_flag_n == (held_r < 10'h200))
		else $error("full flag disagrees with count");
	half_level_a: assert property (quiet_r == 2'h3 |-> half_full_flag_n == (held_r < 10'h101))
		else $error("half-full flag disagrees with count");
	almost_empty_a: assert property (quiet_r == 2'h3 |->
		almost_empty_flag_n == (held_r > {1'b0, empty_offset_i}))
		else $error("almost-empty flag disagrees with count");
	almost_full_a: assert property (quiet_r == 2'h3 |->
		almost_full_flag_n == (held_r < 10'h200 - {1'b0, full_offset_i}))
		else $error("almost-full flag disagrees with count");
	first_write_a: assert property (held_r == 10'h0 && quiet_r == 2'h3 && !wr_en_n |->
		##1 !empty_flag_n ##1 empty_flag_n)
		else $error("empty flag timing wrong after first write");
	full_release_a: assert property (held_r == 10'h200 && quiet_r == 2'h3 && !rd_en_n |->
		##[1:3] full_flag_n)
		else $error("full flag not released by read");
	inactive_pair_a: assert property (!space_avail_flag_n && output_ready_flag_n)
		else $error("fall-through flags active in classic mode");
endmodule : dcf_monitor
`default_nettype wire

//--- tb/tb_dual_clock_fifo_flag_timing.sv
// Bench: a classic pair and a fall-through pair of FIFO ends.
// Assumes the package, interface and both ends compile first.
`timescale 1ns/1ns
`default_nettype none
module tb_dual_clock_fifo_flag_timing;
	import dcf_pkg::*;
	logic      clock_i;
	logic      resetn_i;
	logic      ce;
	dcf_off_t  n_off;
	dcf_off_t  m_off;
	logic      push [2];
	dcf_word_t pdata [2];
	logic      pop [2];
	logic      pready [2];
	logic      pvalid [2];
	dcf_word_t pout [2];
	int        fail_count;
	int        comparisons;
	dcf_if ifc ();
	dcf_if ift ();
	dcf_dev u_dcf_dev (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce), .bus(ifc.dev),
		.empty_offset_i(n_off), .full_offset_i(m_off));
	dcf_dev u_dcf_dev_ft (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce), .bus(ift.dev),
		.empty_offset_i(n_off), .full_offset_i(m_off));
	dcf_usr #(.FALL_THROUGH(DCF_CLASSIC)) u_dcf_usr (.clock_i(clock_i), .resetn_i(resetn_i),
		.ce_i(ce), .bus(ifc.usr), .push_i(push[0]), .push_data_i(pdata[0]),
		.push_ready_o(pready[0]), .pop_i(pop[0]), .pop_data_o(pout[0]),
		.pop_valid_o(pvalid[0]));
	dcf_usr #(.FALL_THROUGH(DCF_FALL_THROUGH)) u_dcf_usr_ft (.clock_i(clock_i),
		.resetn_i(resetn_i), .ce_i(ce), .bus(ift.usr), .push_i(push[1]),
		.push_data_i(pdata[1]), .push_ready_o(pready[1]), .pop_i(pop[1]),
		.pop_data_o(pout[1]), .pop_valid_o(pvalid[1]));
	dcf_monitor u_dcf_monitor (.clock_i(clock_i), .resetn_i(resetn_i), .wr_en_n(ifc.wr_en_n),
		.rd_en_n(ifc.rd_en_n), .empty_flag_n(ifc.empty_flag_n), .full_flag_n(ifc.full_flag_n),
		.output_ready_flag_n(ifc.output_ready_flag_n), .space_avail_flag_n(ifc.space_avail_flag_n),
		.almost_empty_flag_n(ifc.almost_empty_flag_n), .almost_full_flag_n(ifc.almost_full_flag_n),
		.half_full_flag_n(ifc.half_full_flag_n), .empty_offset_i(n_off), .full_offset_i(m_off));
	// Flag vectors are {empty or output-ready, full or input-ready, almost-empty, half, almost-full}.
	function automatic dcf_word_t cflags();
		return dcf_word_t'({ifc.empty_flag_n, ifc.full_flag_n, ifc.almost_empty_flag_n,
			ifc.half_full_flag_n, ifc.almost_full_flag_n});
	endfunction : cflags
	function automatic dcf_word_t fflags();
		return dcf_word_t'({ift.output_ready_flag_n, ift.space_avail_flag_n,
			ift.almost_empty_flag_n, ift.half_full_flag_n, ift.almost_full_flag_n});
	endfunction : fflags
	task automatic check(input string what, input dcf_word_t exp, input dcf_word_t got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic check_reset();
		check("classic reset flags", 72'h0b, cflags());
		check("ft reset flags", 72'h13, fflags());
	endtask : check_reset
	// Pushes past capacity; words beyond it are dropped, so exactly cap words come back.
	task automatic fill_drain(input int i, input int cap, input dcf_word_t full_exp);
		int got;
		got = 0;
		push[i] <= 1'b1;
		repeat (cap + 40) begin
			@(posedge clock_i);
			if (pready[i] === 1'b1)
				pdata[i] <= pdata[i] + 72'h1;
		end
		push[i] <= 1'b0;
		repeat (6) @(posedge clock_i);
		check("full flags", full_exp, i ? fflags() : cflags());
		pop[i] <= 1'b1;
		repeat (cap * 4 + 40) begin
			@(posedge clock_i);
			if (pvalid[i] === 1'b1) begin
				check("popped word", dcf_word_t'(got), pout[i]);
				got++;
			end
		end
		pop[i] <= 1'b0;
		repeat (6) @(posedge clock_i);
		check("words popped", dcf_word_t'(cap), dcf_word_t'(got));
		check("empty flags", i ? 72'h13 : 72'h0b, i ? fflags() : cflags());
	endtask : fill_drain
	task automatic first_word();
		int k;
		pdata <= '{72'habcd, 72'habcd};
		push <= '{1'b1, 1'b1};
		@(posedge clock_i);
		push <= '{1'b0, 1'b0};
		for (k = 0; k < 8 && ift.wr_en_n !== 1'b0; k++)
			@(posedge clock_i);
		if (k == 8) begin
			fail_count++;
			give_verdict();
		end
		repeat (3) @(posedge clock_i);
		check("early word", 72'h0, dcf_word_t'(ift.data_out_bus === 72'habcd));
		@(posedge clock_i);
		check("fall-through word", 72'habcd, ift.data_out_bus);
		repeat (3) @(posedge clock_i);
		check("ft one-word flags", 72'h03, fflags());
		check("classic one-word flags", 72'h1b, cflags());
		check("classic unread output", 72'h0, dcf_word_t'(ifc.data_out_bus === 72'habcd));
		pop <= '{1'b1, 1'b1};
		repeat (8) @(posedge clock_i);
		pop <= '{1'b0, 1'b0};
		repeat (4) @(posedge clock_i);
		check("classic read word", 72'habcd, pout[0]);
		check("ft read word", 72'habcd, pout[1]);
	endtask : first_word
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		resetn_i = 1'b0;
		ce = 1'b1;
		n_off = 9'h4;
		m_off = 9'h8;
		push = '{1'b0, 1'b0};
		pop = '{1'b0, 1'b0};
		pdata = '{72'h0, 72'h0};
		fail_count = 0;
		comparisons = 0;
		repeat (6) @(posedge clock_i);
		check_reset();
		resetn_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		fill_drain(0, 512, 72'h14);
		fill_drain(1, 513, 72'h0c);
		first_word();
		give_verdict();
	end
endmodule : tb_dual_clock_fifo_flag_timing
`default_nettype wire
